//--- aivc_defines.vh
/*
 * Constants for the accumulator / indexed variable command block:
 * frame layout, opcodes, status codes and the X index limit.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AIVC_DEFINES_VH
`define AIVC_DEFINES_VH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define AIVC_FRAME_LEN      4'h9
`define AIVC_IDX_ADDR       4'h0
`define AIVC_IDX_INSTR      4'h1
`define AIVC_IDX_TYPE       4'h2
`define AIVC_IDX_BANK       4'h3
`define AIVC_IDX_VAL3       4'h4
`define AIVC_IDX_VAL0       4'h7
`define AIVC_IDX_CSUM       4'h8
`define AIVC_MODULE_ADDR    8'h01
`define AIVC_HOST_ADDR      8'h02

// ----------------------------------------------------------------------
// Opcodes and status
// ----------------------------------------------------------------------
`define AIVC_OP_ROT_RIGHT   8'h33
`define AIVC_OP_SET_IVAR    8'h37
`define AIVC_OP_GET_IVAR    8'h38
`define AIVC_OP_ACC_IVAR    8'h39
`define AIVC_STATUS_OK      8'h64
`define AIVC_PARAM_TGT_VEL  8'h02
`define AIVC_MOTOR0         8'h00

// ----------------------------------------------------------------------
// Index range of the user variables
// ----------------------------------------------------------------------
`define AIVC_XREG_MAX       32'h000000FF

`endif

//--- aivc_var_store.v
/*
 * User variable store: one synchronous write port, one
 * asynchronous read port. Index range checks are left to the caller.
 */
`timescale 1ns/1ps
module aivc_var_store #(
  parameter DEPTH  = 256,
  parameter AW     = 8,
  parameter DW     = 32
) (
  clock,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  input  wire          clock;
  input  wire          wr_en;
  input  wire [AW-1:0] wr_idx;
  input  wire [DW-1:0] wr_data;
  input  wire [AW-1:0] rd_idx;
  output wire [DW-1:0] rd_data;

  reg [DW-1:0] mem_q [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule

//--- aivc_cmd_exec.v
/*
 * Command interpreter for rotate-right-from-accumulator and the three
 * indexed user variable commands. Takes a byte stream of nine-byte
 * frames, checks address and checksum, executes, and emits a
 * nine-byte reply stream.
 * Assumes byte inputs synchronous to clock; accumulator and X register
 * are loaded by other command logic through the load ports.
 */
// Functional notes
// RL1: Opcode 51 starts rotation toward increasing position at accum velocity.
// RL2: Rotate first selects velocity mode, then copies accum to param 2. Code sets vel_mode and param_wr on the same edge.
// RL3: The velocity value is in microsteps per second, one pulse each.
// RL4: Set-indexed writes the frame value into the variable chosen by X.
// RL5: Indexed commands with X outside 0..255 are ignored, no var changes.
// RL6: Set-indexed uses instruction 37 hex, value in the four value bytes.
// RL7: Instruction 38 hex loads the X-indexed variable into the accum.
// RL8: Instruction 39 hex copies the accum into the X-indexed variable.
// RL9: Each accepted command returns status 100 with undefined value.
// RL10: Frame is address, instr, type, bank, four value bytes MSB first, sum.
// RL11: Type, bank and value of rotate and get are ignored; motor 0 is used.
// RL12: The checksum is the 8-bit sum of eight bytes; bad frames dropped.
`timescale 1ns/1ps
module aivc_cmd_exec #(
  parameter DW = 32
) (
  clock,
  rst_n,
  rx_valid,
  rx_data,
  rx_ready,
  tx_valid,
  tx_data,
  tx_ready,
  acc_load,
  acc_load_val,
  x_load,
  x_load_val,
  accum,
  xreg,
  vel_mode,
  rot_dir_pos,
  param_wr,
  param_num,
  param_motor,
  param_val
);
`include "aivc_defines.vh"
  input  wire          clock;
  input  wire          rst_n;
  input  wire          rx_valid;
  input  wire [7:0]    rx_data;
  output wire          rx_ready;
  output reg           tx_valid;
  output reg  [7:0]    tx_data;
  input  wire          tx_ready;
  input  wire          acc_load;
  input  wire [DW-1:0] acc_load_val;
  input  wire          x_load;
  input  wire [DW-1:0] x_load_val;
  output wire [DW-1:0] accum;
  output wire [DW-1:0] xreg;
  output reg           vel_mode;
  output reg           rot_dir_pos;
  output reg           param_wr;
  output reg  [7:0]    param_num;
  output reg  [7:0]    param_motor;
  output reg  [DW-1:0] param_val;

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_RX   = 2'b00;
  localparam ST_EXEC = 2'b01;
  localparam ST_TX   = 2'b10;

  reg [1:0]    state_q;
  reg [3:0]    cnt_q;
  reg [7:0]    sum_q;
  reg [7:0]    addr_q;
  reg [7:0]    instr_q;
  reg [DW-1:0] val_q;
  reg [DW-1:0] acc_q;
  reg [DW-1:0] x_q;
  reg [7:0]    rcsum_q;

  wire          x_ok;
  wire          ivar_wr;
  wire [DW-1:0] ivar_wdata;
  wire [DW-1:0] ivar_rdata;
  wire          known_op;

  assign accum    = acc_q;
  assign xreg     = x_q;
  assign rx_ready = (state_q == ST_RX);
  // Signed X: negative values fail as well as those above 255
  assign x_ok     = ~x_q[DW-1] && (x_q <= `AIVC_XREG_MAX); // RL5
  assign known_op = (instr_q == `AIVC_OP_ROT_RIGHT) ||
                    (instr_q == `AIVC_OP_SET_IVAR)  ||
                    (instr_q == `AIVC_OP_GET_IVAR)  ||
                    (instr_q == `AIVC_OP_ACC_IVAR);
  assign ivar_wr  = (state_q == ST_EXEC) && x_ok && // RL5
                    ((instr_q == `AIVC_OP_SET_IVAR) || // RL6
                     (instr_q == `AIVC_OP_ACC_IVAR)); // RL8
  assign ivar_wdata = (instr_q == `AIVC_OP_SET_IVAR) ? val_q : acc_q; // RL4

  aivc_var_store #(
    .DEPTH (256),
    .AW    (8),
    .DW    (DW)
  ) u_store (
    .clock   (clock),
    .wr_en   (ivar_wr),
    .wr_idx  (x_q[7:0]),
    .wr_data (ivar_wdata),
    .rd_idx  (x_q[7:0]),
    .rd_data (ivar_rdata)
  );

  // --------------------------------------------------------------------
  // Reply byte selection
  // --------------------------------------------------------------------
  reg [7:0] reply_byte;
  always @* begin
    case (cnt_q)
      4'h0:    reply_byte = `AIVC_HOST_ADDR;
      4'h1:    reply_byte = `AIVC_MODULE_ADDR;
      4'h2:    reply_byte = `AIVC_STATUS_OK; // RL9
      4'h3:    reply_byte = instr_q;
      4'h8:    reply_byte = rcsum_q;
      default: reply_byte = 8'h00; // Value field is don't care
    endcase
  end

  // --------------------------------------------------------------------
  // Main sequencer
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    param_wr <= 1'b0;
    if (!rst_n) begin
      state_q     <= ST_RX;
      cnt_q       <= 4'h0;
      sum_q       <= 8'h00;
      addr_q      <= 8'h00;
      instr_q     <= 8'h00;
      val_q       <= {DW{1'b0}};
      acc_q       <= {DW{1'b0}};
      x_q         <= {DW{1'b0}};
      rcsum_q     <= 8'h00;
      tx_valid    <= 1'b0;
      tx_data     <= 8'h00;
      vel_mode    <= 1'b0;
      rot_dir_pos <= 1'b0;
      param_num   <= 8'h00;
      param_motor <= 8'h00;
      param_val   <= {DW{1'b0}};
    end else begin
      if (acc_load) begin
        acc_q <= acc_load_val;
      end
      if (x_load) begin
        x_q <= x_load_val;
      end
      case (state_q)
        ST_RX: begin
          if (rx_valid) begin
            // Bytes in fixed order; value is shifted MSB first
            case (cnt_q) // RL10
              `AIVC_IDX_ADDR:  addr_q  <= rx_data;
              `AIVC_IDX_INSTR: instr_q <= rx_data;
              default: begin
                if (cnt_q >= `AIVC_IDX_VAL3 && cnt_q <= `AIVC_IDX_VAL0) begin
                  val_q <= {val_q[DW-9:0], rx_data};
                end
              end
            endcase
            if (cnt_q == `AIVC_IDX_CSUM) begin
              cnt_q <= 4'h0;
              sum_q <= 8'h00;
              // Bad sum, foreign address or other opcode: drop silently
              if (rx_data == sum_q && addr_q == `AIVC_MODULE_ADDR && // RL12
                  known_op) begin
                state_q <= ST_EXEC;
              end
            end else begin
              cnt_q <= cnt_q + 4'h1;
              sum_q <= sum_q + rx_data; // RL12
            end
          end
        end
        ST_EXEC: begin
          case (instr_q)
            `AIVC_OP_ROT_RIGHT: begin
              // Type, bank and value ignored; motor 0 always
              vel_mode    <= 1'b1; // RL2
              rot_dir_pos <= 1'b1; // RL1
              param_wr    <= 1'b1; // RL2
              param_num   <= `AIVC_PARAM_TGT_VEL; // RL2
              param_motor <= `AIVC_MOTOR0; // RL11
              param_val   <= acc_q; // RL3
            end
            `AIVC_OP_GET_IVAR: begin
              if (x_ok) begin
                acc_q <= ivar_rdata; // RL7
              end
            end
            default: begin
            end
          endcase
          // Reply checksum: host + module + status + instr, value zero
          rcsum_q <= `AIVC_HOST_ADDR + `AIVC_MODULE_ADDR +
                     `AIVC_STATUS_OK + instr_q; // RL9
          cnt_q   <= 4'h0;
          state_q <= ST_TX;
        end
        ST_TX: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data  <= reply_byte;
          end else if (tx_ready) begin
            if (cnt_q == `AIVC_IDX_CSUM) begin
              tx_valid <= 1'b0;
              cnt_q    <= 4'h0;
              state_q  <= ST_RX;
            end else begin
              tx_valid <= 1'b0;
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        default: state_q <= ST_RX;
      endcase
    end
  end
endmodule

//--- aivc_props.sv
/* Port checks for aivc_cmd_exec. Bound from the bench top. */
`timescale 1ns/1ps
`include "aivc_defines.vh"
module aivc_props #(
  parameter DW = 32
) (
  input wire          clock,
  input wire          rst_n,
  input wire          rx_ready,
  input wire          tx_valid,
  input wire [7:0]    tx_data,
  input wire          tx_ready,
  input wire [DW-1:0] accum,
  input wire          vel_mode,
  input wire          rot_dir_pos,
  input wire          param_wr,
  input wire [7:0]    param_num,
  input wire [7:0]    param_motor,
  input wire [DW-1:0] param_val
);
  // ----
  // Reply byte position
  // ----
  // Counts taken bytes only, so a stalled byte keeps its place
  reg [3:0] pos_q;
  always @(posedge clock)
    if (!rst_n)
      pos_q <= 4'h0;
    else if (tx_valid && tx_ready)
      pos_q <= (pos_q == 4'h8) ? 4'h0 : pos_q + 4'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_wr_one_pulse: assert property (
    param_wr |=> !param_wr) else $error("param_wr too long");
  a_param_target: assert property (
    param_wr |-> param_num == `AIVC_PARAM_TGT_VEL &&
    param_motor == `AIVC_MOTOR0) else $error("bad param target");
  a_param_accum: assert property (
    param_wr |-> param_val == accum) else $error("bad param value");
  a_dir_right: assert property (
    param_wr |=> vel_mode && rot_dir_pos) else $error("bad mode");
  a_reply_start: assert property (
    param_wr |-> ##[0:2] tx_valid) else $error("no reply");
  a_rx_blocked: assert property (
    tx_valid |-> !rx_ready) else $error("rx open in reply");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped");
  a_reply_addr: assert property (
    tx_valid && pos_q == 4'h0 |-> tx_data == `AIVC_HOST_ADDR)
    else $error("bad reply address");
  a_reply_status: assert property (
    tx_valid && pos_q == 4'h2 |-> tx_data == `AIVC_STATUS_OK)
    else $error("bad reply status");
  c_rotate: cover property (param_wr);
  c_stall: cover property (tx_valid && !tx_ready);
  c_last: cover property (tx_valid && tx_ready && pos_q == 4'h8);
endmodule

//--- aivc_host.sv
/* Host model: sends frames, takes replies. Needs the bench clock. */
`timescale 1ns/1ps
module aivc_host (
  input  wire       clock,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  input  wire       rx_ready,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output reg        tx_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  task send(input [71:0] f);
    integer i;
    for (i = 0; i < 9; i = i + 1) begin
      rx_valid = 1'b1;
      rx_data = f[71-8*i -: 8];
      do @(posedge clock); while (rx_ready !== 1'b1);
      #1;
    end
    rx_valid = 1'b0;
    // Released line shows a changed value, not the last byte
    rx_data = ~rx_data;
  endtask
  task recv(output [71:0] r);
    integer j;
    integer w;
    for (j = 0; j < 9; j = j + 1) begin
      // Ready only drops when a stall is drawn, so it never toggles in
      // a single time step
      w = $urandom_range(0, 2);
      if (w > 0) begin
        tx_ready = 1'b0;
        repeat (w) begin
          @(posedge clock);
          #1;
        end
      end
      tx_ready = 1'b1;
      do @(posedge clock); while (tx_valid !== 1'b1);
      r = {r[63:0], tx_data};
      #1;
    end
    tx_ready = 1'b0;
  endtask
endmodule

//--- aivc_tb.sv
/* Bench for aivc_cmd_exec. Host model in aivc_host, checker bound. */
`timescale 1ns/1ps
`include "aivc_defines.vh"
`define CHK(n, e, s) begin n_tests = n_tests + 1; \
  if ((s) !== (e)) begin failures = failures + 1; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module testbench;
  reg         clock;
  reg         rst_n;
  reg         acc_load;
  reg         x_load;
  reg  [31:0] ld_val;
  wire        rx_valid;
  wire        rx_ready;
  wire        tx_valid;
  wire        tx_ready;
  wire [7:0]  rx_data;
  wire [7:0]  tx_data;
  wire [31:0] accum;
  wire [31:0] xreg;
  wire [31:0] param_val;
  wire        vel_mode;
  wire        rot_dir_pos;
  wire [7:0]  param_num;
  integer     failures;
  integer     n_tests;
  integer     t;
  reg  [71:0] rep;
  reg  [31:0] a;
  reg  [31:0] v;
  always #5 clock = ~clock;
  aivc_cmd_exec aivc_cmd_exec_inst (.clock(clock), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .acc_load(acc_load), .acc_load_val(ld_val), .x_load(x_load),
    .x_load_val(ld_val), .accum(accum), .xreg(xreg), .vel_mode(vel_mode),
    .rot_dir_pos(rot_dir_pos), .param_wr(), .param_num(param_num),
    .param_motor(), .param_val(param_val));
  aivc_host aivc_host_inst (.clock(clock), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  function [7:0] cs(input [63:0] h);
    integer k;
    cs = 8'h00;
    for (k = 0; k < 8; k = k + 1)
      cs = cs + h[8*k +: 8];
  endfunction
  function [71:0] mk(input [7:0] ad, input [7:0] op,
                     input [15:0] tm, input [31:0] val);
    mk = {ad, op, tm, val, cs({ad, op, tm, val})};
  endfunction
  task ld(input sel, input [31:0] d);
    acc_load = !sel;
    x_load = sel;
    ld_val = d;
    @(posedge clock);
    #1;
    acc_load = 1'b0;
    x_load = 1'b0;
    // Idle edge so a following load never re-drives a strobe at once
    @(posedge clock);
    #1;
  endtask
  task cmd(input [7:0] op, input [15:0] tm, input [31:0] val);
    aivc_host_inst.send(mk(`AIVC_MODULE_ADDR, op, tm, val));
    aivc_host_inst.recv(rep);
    `CHK("reply", mk(8'h02, 8'h01, {8'h64, op}, 32'h0), rep)
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    acc_load = 1'b0;
    x_load = 1'b0;
    ld_val = 32'h0;
    failures = 0;
    n_tests = 0;
    void'($urandom(56));
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    `CHK("rx_ready", 1'b1, rx_ready)
    for (t = 0; t < 8; t = t + 1) begin
      v = $urandom;
      a = $urandom;
      ld(1'b1, t == 0 ? 32'h0 : t == 1 ? 32'hFF : $urandom % 256);
      cmd(`AIVC_OP_SET_IVAR, 16'h0, v);
      ld(1'b0, 32'h0);
      cmd(`AIVC_OP_GET_IVAR, 16'($urandom), $urandom);
      `CHK("get after set", v, accum)
      ld(1'b0, a);
      cmd(`AIVC_OP_ACC_IVAR, 16'h0, 32'h0);
      ld(1'b0, 32'h0);
      cmd(`AIVC_OP_GET_IVAR, 16'h0, 32'h0);
      `CHK("get after copy", a, accum)
    end
    $display("test indexed done");
    ld(1'b1, 32'hFF);
    cmd(`AIVC_OP_SET_IVAR, 16'h0, v);
    ld(1'b0, ~v);
    ld(1'b1, 32'h100);
    cmd(`AIVC_OP_SET_IVAR, 16'h0, ~v);
    ld(1'b1, 32'hFFFFFFFF);
    cmd(`AIVC_OP_ACC_IVAR, 16'h0, 32'h0);
    cmd(`AIVC_OP_GET_IVAR, 16'h0, 32'h0);
    `CHK("get out of range", ~v, accum)
    ld(1'b1, 32'hFF);
    cmd(`AIVC_OP_GET_IVAR, 16'h0, 32'h0);
    `CHK("var kept", v, accum)
    $display("test range done");
    aivc_host_inst.send(mk(8'h01, `AIVC_OP_SET_IVAR, 16'h0, ~v) ^ 72'h1);
    @(posedge clock);
    #1;
    aivc_host_inst.send(mk(8'h03, `AIVC_OP_SET_IVAR, 16'h0, ~v));
    repeat (20) @(posedge clock);
    #1;
    `CHK("no reply", 1'b0, tx_valid)
    cmd(`AIVC_OP_GET_IVAR, 16'h0, 32'h0);
    `CHK("dropped frame", v, accum)
    $display("test drop done");
    a = $urandom;
    ld(1'b0, a);
    cmd(`AIVC_OP_ROT_RIGHT, 16'($urandom), $urandom);
    `CHK("vel_mode", 1'b1, vel_mode)
    `CHK("rot_dir_pos", 1'b1, rot_dir_pos)
    `CHK("param_val", a, param_val)
    `CHK("param_num", 8'h02, param_num)
    $display("test rotate done");
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    `CHK("vel_mode reset", 1'b0, vel_mode)
    `CHK("accum reset", 32'h0, accum)
    `CHK("rx_ready reset", 1'b1, rx_ready)
    ld(1'b1, 32'hFF);
    `CHK("xreg", 32'hFF, xreg)
    cmd(`AIVC_OP_GET_IVAR, 16'h0, 32'h0);
    `CHK("var after reset", v, accum)
    cmd(`AIVC_OP_ROT_RIGHT, 16'h0, 32'h0);
    `CHK("vel_mode again", 1'b1, vel_mode)
    `CHK("param_val again", v, param_val)
    $display("test reset done");
    give_verdict;
  end
endmodule
bind aivc_cmd_exec aivc_props #(.DW(DW)) aivc_props_inst (.clock(clock),
  .rst_n(rst_n), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .accum(accum),
  .vel_mode(vel_mode), .rot_dir_pos(rot_dir_pos), .param_wr(param_wr),
  .param_num(param_num), .param_motor(param_motor),
  .param_val(param_val));
